// File: hdl/itu_top.v
`include "itu_regs.vh"

module itu_timer (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // control
  input wire tick,
  input wire start,
  input wire stop,
  input wire auto_reload,
  input wire [15:0] reload,
  // state
  output reg [15:0] count,
  output reg running,
  output reg underflow
);

  // start reloads even while running, so a host restart begins a fresh
  // period, unless stop is high in the same cycle, instead of finishing the old one
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 16'h0000;
      running <= 1'b0;
      underflow <= 1'b0;
    end else begin
      underflow <= 1'b0;
      if (stop) begin
        // stop beats a same-cycle underflow, so no flag
        running <= 1'b0;
      end else if (start) begin
        running <= 1'b1;
        count <= reload;
      end else if (running && tick) begin
        if (count == 16'h0000) begin
          underflow <= 1'b1;
          if (auto_reload) begin
            count <= reload;
          end else begin
            running <= 1'b0;
          end
        end else begin
          count <= count - 16'h0001;
        end
      end
    end
  end

endmodule

module itu_top (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // register bank port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // event sources
  input wire tx_eof_start,
  input wire rx_stream_end,
  input wire cmd_idle_done,
  input wire [9:0] fifo_count,
  input wire [7:0] rx_error,
  input wire card_found,
  input wire low_power_card_detection_active,
  input wire low_power_card_detection_no_card,
  input wire rx_frame_start,
  // timer clocking and stop events
  input wire tick_13m56,
  input wire tick_212k,
  input wire [3:0] timer_stop_evt,
  // outputs
  output reg irq_pin,
  output reg wake_req,
  output reg standby_req
);

  // cycle count is an integer; cut to the divider width on purpose
  localparam integer LFO_LAST_I = `ITU_LFO_CYCLES - 1;
  localparam [9:0] LFO_LAST = LFO_LAST_I[9:0];

  // interrupt state
  reg [6:0] flags_a;
  reg [5:0] flags_b;
  reg [7:0] en_a;
  reg [7:0] en_b;
  reg summary;

  // fifo and timer configuration
  reg [7:0] wmark;
  reg wmark_ext;
  reg [7:0] tctl [0:4];
  reg [7:0] rld_hi [0:4];
  reg [7:0] rld_lo [0:4];
  reg [9:0] lfo_cnt;
  reg lfo_tick;
  reg [7:0] rd_val;

  // per-timer state and controls
  wire [15:0] cnt [0:4];
  wire [4:0] run;
  wire [4:0] uf;
  wire [4:0] t_start;
  wire [4:0] t_stop;
  wire [4:0] t_tick;

  // address decode
  wire wr_fa = reg_wr && (reg_addr == `ITU_ADDR_FLAGS_A);
  wire wr_fb = reg_wr && (reg_addr == `ITU_ADDR_FLAGS_B);
  wire wr_ea = reg_wr && (reg_addr == `ITU_ADDR_EN_A);
  wire wr_eb = reg_wr && (reg_addr == `ITU_ADDR_EN_B);
  wire wr_tc = reg_wr && (reg_addr == `ITU_ADDR_TCTRL);

  // eight bytes per timer window, first window at 10h
  wire t_hit = (reg_addr >= `ITU_ADDR_TMR_FIRST) && (reg_addr < `ITU_ADDR_TMR_END);
  wire [2:0] t_idx = reg_addr[5:3] - 3'h2;
  wire [2:0] t_off = reg_addr[2:0];
  wire wr_mode = reg_wr && t_hit && (t_off == `ITU_TOFF_MODE);

  // fifo thresholds, top counted down from the full size
  // ext bit lets the top distance reach past 255 words
  wire [9:0] wm_top = `ITU_FIFO_SIZE - {1'b0, wmark_ext, wmark};
  wire hi_status = fifo_count >= wm_top;
  wire lo_status = fifo_count <= {2'b00, wmark};

  wire [6:0] hw_a = {hi_status, lo_status, cmd_idle_done, tx_eof_start,
                     rx_stream_end, |rx_error, rx_frame_start};
  wire [5:0] hw_b = {card_found && low_power_card_detection_active, uf};

  // bit 7 of a write is the operation, never stored
  function [7:0] set_clr;
    input [7:0] old;
    input [7:0] wd;
    begin
      if (wd[`ITU_BIT_SETCLR]) begin
        set_clr = old | {1'b0, wd[6:0]};
      end else begin
        set_clr = old & ~{1'b0, wd[6:0]};
      end
    end
  endfunction

  wire [7:0] fa_w = set_clr({1'b0, flags_a}, reg_wdata);
  wire [7:0] fb_w = set_clr({2'b00, flags_b}, reg_wdata);
  wire [6:0] next_flags_a = (wr_fa ? fa_w[6:0] : flags_a) | hw_a;
  wire [5:0] next_flags_b = (wr_fb ? fb_w[5:0] : flags_b) | hw_b;
  // summary is registered so the pin and the status bit move together
  wire next_summary = |(next_flags_a & en_a[6:0]) | |(next_flags_b & en_b[5:0]);

  // flags: a hardware set in the clear cycle still lands
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_a <= 7'h00;
      flags_b <= 6'h00;
      en_a <= `ITU_RST_BYTE;
      en_b <= `ITU_RST_BYTE;
      summary <= 1'b0;
      irq_pin <= 1'b0;
    end else begin
      flags_a <= next_flags_a;
      flags_b <= next_flags_b;
      if (wr_ea) begin
        en_a <= set_clr(en_a, reg_wdata);
      end
      if (wr_eb) begin
        en_b <= set_clr(en_b, reg_wdata);
      end
      summary <= next_summary;
      irq_pin <= next_summary && en_b[`ITU_BIT_PIN_EN];
    end
  end

  // fifo and timer configuration registers
  // counts are not writable; a start or an auto-reload underflow loads them from the reload bytes
  integer i;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wmark <= `ITU_RST_BYTE;
      wmark_ext <= 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
        tctl[i] <= `ITU_RST_BYTE;
        rld_hi[i] <= `ITU_RST_BYTE;
        rld_lo[i] <= `ITU_RST_BYTE;
      end
    end else if (reg_wr) begin
      if (reg_addr == `ITU_ADDR_WMARK) begin
        wmark <= reg_wdata;
      end else if (reg_addr == `ITU_ADDR_WMARK_EXT) begin
        wmark_ext <= reg_wdata[0];
      end else if (t_hit) begin
        for (i = 0; i < 5; i = i + 1) begin
          if (t_idx == i) begin
            if (t_off == `ITU_TOFF_CTRL) begin
              tctl[i] <= reg_wdata;
            end else if (t_off == `ITU_TOFF_RLD_HI) begin
              rld_hi[i] <= reg_wdata;
            end else if (t_off == `ITU_TOFF_RLD_LO) begin
              rld_lo[i] <= reg_wdata;
            end
          end
        end
      end
    end
  end

  // stand-in for the low-frequency oscillator, a divided enable
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lfo_cnt <= 10'h000;
      lfo_tick <= 1'b0;
    end else begin
      lfo_tick <= (lfo_cnt == LFO_LAST);
      if (lfo_cnt == LFO_LAST) begin
        lfo_cnt <= 10'h000;
      end else begin
        lfo_cnt <= lfo_cnt + 10'h001;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : tmr
      if (g < 4) begin : gen_std
        // cascade from the wake timer gives long delays on 16 bits
        wire [1:0] sel = tctl[g][1:0];
        assign t_tick[g] = (sel == `ITU_SEL_FAST) ? tick_13m56 :
                           (sel == `ITU_SEL_SLOW) ? tick_212k : uf[4];
        assign t_start[g] = (wr_tc && reg_wdata[g + 4] && reg_wdata[g]) ||
                            (wr_mode && t_idx == g && reg_wdata[`ITU_MODE_START]);
        assign t_stop[g] = (wr_tc && reg_wdata[g + 4] && !reg_wdata[g]) ||
                           (tctl[g][`ITU_TC_STOP_EN] && timer_stop_evt[g]);
      end else begin : gen_wake
        assign t_tick[g] = lfo_tick;
        assign t_start[g] = wr_mode && t_idx == g && reg_wdata[`ITU_MODE_START];
        assign t_stop[g] = wr_mode && t_idx == g && reg_wdata[`ITU_MODE_STOP];
      end
      itu_timer u_tmr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(t_tick[g]),
        .start(t_start[g]),
        .stop(t_stop[g]),
        .auto_reload(tctl[g][`ITU_TC_AUTO_RLD]),
        .reload({rld_hi[g], rld_lo[g]}),
        .count(cnt[g]),
        .running(run[g]),
        .underflow(uf[g])
      );
    end
  endgenerate

  // wake timer drives the standby cycle; without auto-wake the
  // device stays powered after a failed detection
  wire next_wake_req = uf[4] && tctl[4][`ITU_TC_AUTO_WAKE];
  wire next_standby_req = low_power_card_detection_no_card && tctl[4][`ITU_TC_AUTO_WAKE];

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wake_req <= 1'b0;
      standby_req <= 1'b0;
    end else begin
      wake_req <= next_wake_req;
      standby_req <= next_standby_req;
    end
  end

  // read mux; unmapped addresses read zero
  // reads have no side effects: flags clear only by an explicit write
  always @* begin
    rd_val = 8'h00;
    if (reg_addr == `ITU_ADDR_FLAGS_A) begin
      rd_val = {1'b0, flags_a};
    end else if (reg_addr == `ITU_ADDR_FLAGS_B) begin
      rd_val = {1'b0, summary, flags_b};
    end else if (reg_addr == `ITU_ADDR_EN_A) begin
      rd_val = en_a;
    end else if (reg_addr == `ITU_ADDR_EN_B) begin
      rd_val = en_b;
    end else if (reg_addr == `ITU_ADDR_STATUS1) begin
      rd_val = {7'h00, summary};
    end else if (reg_addr == `ITU_ADDR_TCTRL) begin
      rd_val = {4'h0, run[3:0]};
    end else if (reg_addr == `ITU_ADDR_WMARK) begin
      rd_val = wmark;
    end else if (reg_addr == `ITU_ADDR_WMARK_EXT) begin
      rd_val = {7'h00, wmark_ext};
    end else if (t_hit) begin
      if (t_off == `ITU_TOFF_CTRL) begin
        rd_val = tctl[t_idx];
      end else if (t_off == `ITU_TOFF_MODE) begin
        rd_val = {7'h00, run[t_idx]};
      end else if (t_off == `ITU_TOFF_RLD_HI) begin
        rd_val = rld_hi[t_idx];
      end else if (t_off == `ITU_TOFF_RLD_LO) begin
        rd_val = rld_lo[t_idx];
      end else if (t_off == `ITU_TOFF_CNT_HI) begin
        rd_val = cnt[t_idx][15:8];
      end else if (t_off == `ITU_TOFF_CNT_LO) begin
        rd_val = cnt[t_idx][7:0];
      end
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end
  end

endmodule

// File: pkg/itu_regs.vh
`ifndef ITU_REGS_VH
`define ITU_REGS_VH
`define ITU_ADDR_FLAGS_A 8'h00
`define ITU_ADDR_FLAGS_B 8'h01
`define ITU_ADDR_EN_A 8'h02
`define ITU_ADDR_EN_B 8'h03
`define ITU_ADDR_STATUS1 8'h04
`define ITU_ADDR_TCTRL 8'h05
`define ITU_ADDR_WMARK 8'h06
`define ITU_ADDR_WMARK_EXT 8'h07
`define ITU_ADDR_TMR_FIRST 8'h10
`define ITU_ADDR_TMR_END 8'h38
`define ITU_TOFF_CTRL 3'h0
`define ITU_TOFF_MODE 3'h1
`define ITU_TOFF_RLD_HI 3'h2
`define ITU_TOFF_RLD_LO 3'h3
`define ITU_TOFF_CNT_HI 3'h4
`define ITU_TOFF_CNT_LO 3'h5
`define ITU_BIT_SETCLR 7
`define ITU_BIT_SUMMARY 6
`define ITU_BIT_PIN_EN 6
`define ITU_TC_AUTO_RLD 2
`define ITU_TC_AUTO_WAKE 3
`define ITU_TC_STOP_EN 4
`define ITU_MODE_START 0
`define ITU_MODE_STOP 1
`define ITU_SEL_FAST 2'h0
`define ITU_SEL_SLOW 2'h1
`define ITU_RST_BYTE 8'h00
`define ITU_FIFO_SIZE 10'h200
`define ITU_SYS_PERIOD_NS 100
`define ITU_LFO_PERIOD_NS 100000
`define ITU_LFO_CYCLES (`ITU_LFO_PERIOD_NS / `ITU_SYS_PERIOD_NS)
`endif

// File: tb/itu_host.sv
`include "itu_regs.vh"
module itu_host (
  // clock
  input wire sys_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // bit7 picks set or clear of the ones below
  task setb(input logic [7:0] a, input logic [7:0] m);
    wr(a, 8'h80 | m);
  endtask
  task clrb(input logic [7:0] a, input logic [7:0] m);
    wr(a, m & 8'h7F);
  endtask
  // data taken one edge late: it holds until the next read
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    @(posedge sys_clk);
    #1 d = reg_rdata;
  endtask
endmodule

// File: tb/itu_checker.sv
`include "itu_regs.vh"
module itu_checker (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // events and outputs
  input wire [7:0] rx_error,
  input wire low_power_card_detection_no_card,
  input wire irq_pin,
  input wire wake_req,
  input wire standby_req
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr == 8'h08 |-> ##2 reg_rdata == 8'h00) else $error("unmapped read");
  chk_flag_top_zero: assert property (
    reg_rd && reg_addr == `ITU_ADDR_FLAGS_A |-> ##2 !reg_rdata[7]) else $error("flag bit7");
  chk_set_write: assert property (
    reg_wr && reg_addr == `ITU_ADDR_EN_A && reg_wdata[7] ##2 reg_rd && reg_addr == `ITU_ADDR_EN_A
    |-> ##2 (reg_rdata & $past(reg_wdata, 4) & 8'h7F) == ($past(reg_wdata, 4) & 8'h7F))
    else $error("set write lost");
  chk_error_flag: assert property (
    reg_rd && reg_addr == `ITU_ADDR_FLAGS_A && $past(rx_error) != 8'h00 |-> ##2 reg_rdata[1])
    else $error("error flag");
  chk_pin_gate: assert property (
    reg_wr && reg_addr == `ITU_ADDR_EN_B && !reg_wdata[7] && reg_wdata[6] |-> ##2 !irq_pin)
    else $error("pin not gated");
  chk_wake_gap: assert property (
    wake_req |=> !wake_req [*8]) else $error("wake pulse");
  chk_standby_cause: assert property (
    standby_req |-> $past(low_power_card_detection_no_card)) else $error("standby cause");
  chk_tctrl_upper: assert property (
    reg_rd && reg_addr == `ITU_ADDR_TCTRL |-> ##2 reg_rdata[7:4] == 4'h0)
    else $error("control upper");
endmodule
bind itu_top itu_checker u_chk (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .rx_error, .low_power_card_detection_no_card, .irq_pin, .wake_req, .standby_req);

// File: tb/tb.sv
`include "itu_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, resetn, reg_wr, reg_rd, irq_pin, wake_req, standby_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_error, rv;
  logic [9:0] fifo_count;
  logic [11:0] pv;
  logic low_power_card_detection_active;
  int errors, total_checks, n;
  itu_host u_host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  itu_top u_dut (.sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tx_eof_start(pv[2]), .rx_stream_end(pv[1]), .cmd_idle_done(pv[3]), .fifo_count,
    .rx_error, .card_found(pv[6]), .low_power_card_detection_active, .low_power_card_detection_no_card(pv[7]),
    .rx_frame_start(pv[0]), .tick_13m56(pv[4]), .tick_212k(pv[5]),
    .timer_stop_evt(pv[11:8]), .irq_pin, .wake_req, .standby_req);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task rdc(input string s, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    u_host.rd(a, rv);
    cmp(s, e, rv & m);
  endtask
  task pul(input logic [11:0] v);
    @(posedge sys_clk);
    #1 pv = v;
    @(posedge sys_clk);
    #1 pv = 12'h000;
  endtask
  task t_regs;
    for (int a = 0; a < 4; a++) rdc("reset value", a, 8'hFF, 8'h00);
    u_host.setb(`ITU_ADDR_EN_A, 8'h7F);
    rdc("enable set", `ITU_ADDR_EN_A, 8'hFF, 8'h7F);
    u_host.clrb(`ITU_ADDR_EN_A, 8'h05);
    rdc("enable clear", `ITU_ADDR_EN_A, 8'hFF, 8'h7A);
    rdc("unmapped", 8'h08, 8'hFF, 8'h00);
    $display("regs test done");
  endtask
  task t_irq;
    u_host.setb(`ITU_ADDR_EN_B, 8'h40);
    pul(12'h001);
    rdc("summary masked", `ITU_ADDR_FLAGS_B, 8'h40, 8'h00);
    u_host.setb(`ITU_ADDR_EN_A, 8'h01);
    rdc("summary", `ITU_ADDR_FLAGS_B, 8'h40, 8'h40);
    rdc("status irq", `ITU_ADDR_STATUS1, 8'h01, 8'h01);
    cmp("pin", 8'h01, {7'h00, irq_pin});
    u_host.clrb(`ITU_ADDR_FLAGS_A, 8'h01);
    rdc("summary gone", `ITU_ADDR_FLAGS_B, 8'h40, 8'h00);
    cmp("pin low", 8'h00, {7'h00, irq_pin});
    u_host.clrb(`ITU_ADDR_EN_B, 8'h40);
    $display("irq test done");
  endtask
  task t_events;
    logic [7:0] fb [4] = '{8'h01, 8'h04, 8'h08, 8'h10};
    for (int i = 0; i < 4; i++) begin
      pul(12'h001 << i);
      rdc("event flag", `ITU_ADDR_FLAGS_A, 8'h1D, fb[i]);
      u_host.clrb(`ITU_ADDR_FLAGS_A, 8'h7F);
    end
    rx_error = 8'h20;
    rdc("error flag", `ITU_ADDR_FLAGS_A, 8'h02, 8'h02);
    rx_error = 8'h00;
    u_host.wr(`ITU_ADDR_WMARK, 8'h04);
    fifo_count = 10'd4;
    rdc("low alert", `ITU_ADDR_FLAGS_A, 8'h60, 8'h20);
    fifo_count = 10'd507;
    u_host.clrb(`ITU_ADDR_FLAGS_A, 8'h7F);
    rdc("no alert", `ITU_ADDR_FLAGS_A, 8'h62, 8'h00);
    fifo_count = 10'd508;
    rdc("high alert", `ITU_ADDR_FLAGS_A, 8'h60, 8'h40);
    fifo_count = 10'd256;
    pul(12'h040);
    rdc("card idle", `ITU_ADDR_FLAGS_B, 8'h20, 8'h00);
    low_power_card_detection_active = 1'b1;
    pul(12'h040);
    rdc("card flag", `ITU_ADDR_FLAGS_B, 8'h20, 8'h20);
    $display("events test done");
  endtask
  task t_timer;
    u_host.wr(8'h13, 8'h02);
    u_host.wr(8'h11, 8'h01);
    pul(12'h020);
    rdc("slow ignored", 8'h15, 8'hFF, 8'h02);
    pul(12'h010);
    rdc("count low", 8'h15, 8'hFF, 8'h01);
    pul(12'h010);
    rdc("zero no flag", `ITU_ADDR_FLAGS_B, 8'h01, 8'h00);
    pul(12'h010);
    rdc("underflow", `ITU_ADDR_FLAGS_B, 8'h01, 8'h01);
    rdc("stopped", `ITU_ADDR_TCTRL, 8'h01, 8'h00);
    u_host.wr(8'h18, 8'h15);
    u_host.wr(8'h1B, 8'h01);
    u_host.wr(`ITU_ADDR_TCTRL, 8'h22);
    rdc("running", `ITU_ADDR_TCTRL, 8'h02, 8'h02);
    pul(12'h020);
    pul(12'h020);
    rdc("periodic flag", `ITU_ADDR_FLAGS_B, 8'h02, 8'h02);
    rdc("reloaded", 8'h1D, 8'hFF, 8'h01);
    u_host.clrb(`ITU_ADDR_FLAGS_B, 8'h02);
    pul(12'h200);
    pul(12'h020);
    pul(12'h020);
    rdc("stop event", `ITU_ADDR_FLAGS_B, 8'h02, 8'h00);
    u_host.wr(`ITU_ADDR_TCTRL, 8'h22);
    u_host.wr(`ITU_ADDR_TCTRL, 8'h20);
    rdc("host stop", `ITU_ADDR_TCTRL, 8'h02, 8'h00);
    $display("timer test done");
  endtask
  task t_wake;
    u_host.wr(8'h33, 8'h01);
    u_host.wr(8'h30, 8'h0C);
    u_host.wr(8'h31, 8'h01);
    for (n = 0; wake_req !== 1'b1 && n < 2500; n++) @(posedge sys_clk) #1;
    cmp("first wake", 8'h01, {7'h00, n > 999 && n < 2500});
    @(posedge sys_clk) #1;
    for (n = 1; wake_req !== 1'b1 && n < 2100; n++) @(posedge sys_clk) #1;
    cmp("wake period", 8'h01, {7'h00, n > 1990 && n < 2010});
    pul(12'h080);
    cmp("standby", 8'h01, {7'h00, standby_req});
    u_host.wr(8'h30, 8'h04);
    pul(12'h080);
    cmp("no standby", 8'h00, {7'h00, standby_req});
    $display("wake test done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    errors++;
    complete_run;
  end
  initial begin
    resetn = 1'b0;
    pv = 12'h000;
    rx_error = 8'h00;
    fifo_count = 10'd256;
    low_power_card_detection_active = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 resetn = 1'b1;
    t_regs;
    t_irq;
    t_events;
    t_timer;
    t_wake;
    complete_run;
  end
endmodule
